// ===== interrupt_event_pin_logic.sv
// Interrupt flag banks, request pins and live event output behind a Wishbone slave
//
// Summary of operation
// - Request pin goes low on enabled event, stays low until acknowledged.
// - First pin uses first 32-bit enable bank, second pin the second.
// - Each event owns one bit in an enable bank and its flag bank.
// - Enable bit set lets the event drive its pin; cleared blocks it, except for first-bank bits 0 and 1.
// - Flag sets on its event regardless of the enable bit.
// - Writing one clears a flag; pin returns high once enabled flags clear.
// - Reset-complete and fault-zero flags interrupt even with enable bit zero.
// - Merge bit makes second pin show both banks; first shows its own.
// - Phase A voltage zero crossing sets its second-bank flag and pin.
// - Shared pin shows the event function only when select equals binary 10.
// - Every event source is maskable and disabled after reset.
// - A source feeds the event output only when its enable bit is one.
// - Event output low while any enabled source active, else high.
// - Event output is not latched; it follows its sources.
// - Event output polarity is fixed, with no invert control.
// - Idle flags of second bank have per-phase detail in a register.
// - Reverse power flags of first bank have per-phase sign detail register.
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`include "irq_event_cfg.svh"
module interrupt_event_pin_logic (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic [31:0] EVENT_FIRST,
  input  wire logic [31:0] EVENT_SECOND,
  input  wire logic [31:0] EVENT_LIVE,
  input  wire logic [31:0] PER_PHASE_IDLE,
  input  wire logic [31:0] PER_PHASE_SIGN,
  input  wire logic        PULSE_OUT_FOUR,
  input  wire logic        SAMPLE_READY_OUT,
  output logic             INT_PIN_FIRST_N,
  output logic             INT_PIN_SECOND_N,
  output logic             SHARED_PIN
);

  // Byte-lane write merge, used for every configuration register
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val, input logic [31:0] wr_val,
                                             input logic [3:0] lanes);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (lanes[i])
      begin
        res[i*8 +: 8] = wr_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // Write-one-to-clear mask limited to the selected byte lanes
  function automatic logic [31:0] clear_mask(input logic [31:0] wr_val, input logic [3:0] lanes);
    logic [31:0] res;
    res = 32'h00000000;
    for (int i = 0; i < 4; i++)
    begin
      if (lanes[i])
      begin
        res[i*8 +: 8] = wr_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : clear_mask

  irq_event_pkg::state_t  st_reg;
  irq_event_pkg::state_t  st_next;
  irq_event_pkg::wb_req_t req;
  logic [31:0]            ev_first_meta;
  logic [31:0]            ev_first_sync;
  logic [31:0]            ev_second_meta;
  logic [31:0]            ev_second_sync;
  logic [31:0]            ev_live_meta;
  logic [31:0]            ev_live_sync;
  logic [31:0]            idle_meta;
  logic [31:0]            sign_meta;
  logic [1:0]             pin_meta;
  logic [1:0]             pin_sync;

  // Event sources come from the metrology core timing; two stages before use
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ev_first_meta  <= 32'h00000000;
      ev_first_sync  <= 32'h00000000;
      ev_second_meta <= 32'h00000000;
      ev_second_sync <= 32'h00000000;
      ev_live_meta   <= 32'h00000000;
      ev_live_sync   <= 32'h00000000;
      idle_meta      <= 32'h00000000;
      sign_meta      <= 32'h00000000;
      pin_meta       <= 2'h0;
      pin_sync       <= 2'h0;
    end
    else
    begin
      ev_first_meta  <= EVENT_FIRST;
      ev_first_sync  <= ev_first_meta;
      ev_second_meta <= EVENT_SECOND;
      ev_second_sync <= ev_second_meta;
      ev_live_meta   <= EVENT_LIVE;
      ev_live_sync   <= ev_live_meta;
      idle_meta      <= PER_PHASE_IDLE;
      sign_meta      <= PER_PHASE_SIGN;
      pin_meta       <= {SAMPLE_READY_OUT, PULSE_OUT_FOUR};
      pin_sync       <= pin_meta;
    end
  end

  // Bundle the bus request
  always_comb
  begin
    req.cyc = WB_CYC_I;
    req.stb = WB_STB_I;
    req.we  = WB_WE_I;
    req.adr = WB_ADR_I;
    req.sel = WB_SEL_I;
    req.dat = WB_DAT_I;
  end

  // Next state: flags, registers, bus answer and pin levels
  always_comb
  begin
    logic        wr;
    logic        rd_cycle;
    logic [31:0] clr;
    logic [31:0] act_first;
    logic [31:0] act_second;
    logic        any_first;
    logic        any_second;
    logic        ev_active;
    wr         = 1'b0;
    rd_cycle   = 1'b0;
    clr        = 32'h00000000;
    act_first  = 32'h00000000;
    act_second = 32'h00000000;
    any_first  = 1'b0;
    any_second = 1'b0;
    ev_active  = 1'b0;
    st_next    = st_reg;

    // One access per bus cycle; ack drops the cycle after it was given
    rd_cycle = req.cyc && req.stb && (st_reg.bus == irq_event_pkg::BUS_IDLE);
    wr       = rd_cycle && req.we;
    clr      = clear_mask(req.dat, req.sel);
    st_next.bus = rd_cycle ? irq_event_pkg::BUS_ACK : irq_event_pkg::BUS_IDLE;

    // Clear first, then set, so a same-cycle event is never lost
    if (wr && (req.adr == `OFS_FLAG_BANK_FIRST))
    begin
      st_next.flag_first = st_reg.flag_first & ~clr;
    end
    if (wr && (req.adr == `OFS_FLAG_BANK_SECOND))
    begin
      st_next.flag_second = st_reg.flag_second & ~clr;
    end
    st_next.flag_first  = st_next.flag_first | ev_first_sync;
    st_next.flag_second = st_next.flag_second | ev_second_sync;

    // Detail registers track their sources live
    st_next.ph_idle = idle_meta;
    st_next.ph_sign = sign_meta;

    // Writable configuration
    if (wr)
    begin
      unique case (req.adr)
        `OFS_ENABLE_BANK_FIRST:  st_next.en_first  = lane_merge(st_reg.en_first, req.dat, req.sel);
        `OFS_ENABLE_BANK_SECOND: st_next.en_second = lane_merge(st_reg.en_second, req.dat, req.sel);
        `OFS_SETUP_REG_ONE:      st_next.setup     = lane_merge(st_reg.setup, req.dat, req.sel);
        `OFS_EVENT_ENABLE:       st_next.ev_en     = lane_merge(st_reg.ev_en, req.dat, req.sel);
        default:                 st_next.setup     = st_next.setup;
      endcase
    end

    // Read mux; unmapped offsets read zero and still ack
    if (rd_cycle && !req.we)
    begin
      unique case (req.adr)
        `OFS_FLAG_BANK_FIRST:    st_next.dat_out = st_reg.flag_first;
        `OFS_FLAG_BANK_SECOND:   st_next.dat_out = st_reg.flag_second;
        `OFS_ENABLE_BANK_FIRST:  st_next.dat_out = st_reg.en_first;
        `OFS_ENABLE_BANK_SECOND: st_next.dat_out = st_reg.en_second;
        `OFS_SETUP_REG_ONE:      st_next.dat_out = st_reg.setup;
        `OFS_EVENT_ENABLE:       st_next.dat_out = st_reg.ev_en;
        `OFS_PER_PHASE_IDLE:     st_next.dat_out = st_reg.ph_idle;
        `OFS_PER_PHASE_SIGN:     st_next.dat_out = st_reg.ph_sign;
        `OFS_EVENT_LIVE:         st_next.dat_out = ev_live_sync;
        default:                 st_next.dat_out = 32'h00000000;
      endcase
    end

    // Request pins from registered flags; two banks gated by their enables, first-bank bits 0 and 1 always pass
    act_first  = st_reg.flag_first & (st_reg.en_first | `NONMASK_FIRST);
    act_second = st_reg.flag_second & st_reg.en_second;
    any_first  = |act_first;
    any_second = |act_second;
    st_next.int_first_n  = ~any_first;
    st_next.int_second_n = ~(any_second | (st_reg.setup[`BIT_MERGE_INT_LINES] & any_first));

    // Live event level, unlatched and fixed active low
    ev_active = |(ev_live_sync & st_reg.ev_en);
    unique case (st_reg.setup[`BIT_SHARED_PIN_HI:`BIT_SHARED_PIN_LO])
      `SHARED_PIN_EVENT: st_next.shared_out = ~ev_active;
      2'h3:              st_next.shared_out = pin_sync[1];
      default:           st_next.shared_out = pin_sync[0];
    endcase
  end

  // State register; reset clears flags and every enable bit
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      st_reg              <= '0;
      st_reg.en_first     <= `RST_ENABLE_BANK;
      st_reg.en_second    <= `RST_ENABLE_BANK;
      st_reg.setup        <= `RST_SETUP_REG_ONE;
      st_reg.ev_en        <= `RST_EVENT_ENABLE;
      st_reg.bus          <= irq_event_pkg::BUS_IDLE;
      st_reg.int_first_n  <= 1'b1;
      st_reg.int_second_n <= 1'b1;
      st_reg.shared_out   <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign WB_ACK_O         = (st_reg.bus == irq_event_pkg::BUS_ACK);
  assign WB_DAT_O         = st_reg.dat_out;
  assign INT_PIN_FIRST_N  = st_reg.int_first_n;
  assign INT_PIN_SECOND_N = st_reg.int_second_n;
  assign SHARED_PIN       = st_reg.shared_out;

endmodule : interrupt_event_pin_logic

// ===== irq_event_cfg.svh
// Register offsets, bit positions and reset values of the interrupt and event block
`ifndef IRQ_EVENT_CFG_SVH
`define IRQ_EVENT_CFG_SVH
`define OFS_FLAG_BANK_FIRST    8'h00
`define OFS_FLAG_BANK_SECOND   8'h04
`define OFS_ENABLE_BANK_FIRST  8'h08
`define OFS_ENABLE_BANK_SECOND 8'h0C
`define OFS_SETUP_REG_ONE      8'h10
`define OFS_EVENT_ENABLE       8'h14
`define OFS_PER_PHASE_IDLE     8'h18
`define OFS_PER_PHASE_SIGN     8'h1C
`define OFS_EVENT_LIVE         8'h20
`define BIT_RESET_COMPLETE     5'd0
`define BIT_FAULT_ZERO         5'd1
`define BIT_ACTIVE_REVERSE     5'd2
`define BIT_REACTIVE_REVERSE   5'd3
`define BIT_SUM_REVERSE        5'd4
`define BIT_VA_ZERO_CROSS      5'd0
`define BIT_FUND_REACTIVE_IDLE 5'd1
`define BIT_APPARENT_IDLE      5'd2
`define BIT_ACTIVE_IDLE        5'd3
`define BIT_MERGE_INT_LINES    5'd0
`define BIT_SHARED_PIN_LO      5'd1
`define BIT_SHARED_PIN_HI      5'd2
`define SHARED_PIN_EVENT       2'h2
`define RST_ENABLE_BANK        32'h00000000
`define RST_SETUP_REG_ONE      32'h00000000
`define RST_EVENT_ENABLE       32'h00000000
`define NONMASK_FIRST          32'h00000003
`endif

// ===== irq_event_pkg.sv
// Types shared by the interrupt and event block
package irq_event_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;
  typedef struct packed {
    logic [31:0] flag_first;
    logic [31:0] flag_second;
    logic [31:0] en_first;
    logic [31:0] en_second;
    logic [31:0] setup;
    logic [31:0] ev_en;
    logic [31:0] ph_idle;
    logic [31:0] ph_sign;
    logic [31:0] dat_out;
    bus_state_t  bus;
    logic        int_first_n;
    logic        int_second_n;
    logic        shared_out;
  } state_t;
endpackage : irq_event_pkg

// ===== interrupt_event_pin_logic_monitor.sv
// Port-level assertions of the interrupt and event block
`timescale 1ns/1ps
module interrupt_event_pin_logic_monitor (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic [31:0] EVENT_FIRST,
  input wire logic [31:0] EVENT_SECOND,
  input wire logic        INT_PIN_FIRST_N,
  input wire logic        INT_PIN_SECOND_N
);
  logic [3:0] quiet_reg;
  logic [3:0] quiet_next;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Cycles since the last event or bus write; saturates so it never wraps into a false cause
  always_comb
  begin
    quiet_next = (quiet_reg == 4'hF) ? quiet_reg : quiet_reg + 4'h1;
    if ((EVENT_FIRST | EVENT_SECOND) != 32'h0 || (WB_CYC_I && WB_WE_I))
      quiet_next = 4'h0;
  end
  always_ff @(posedge CLK)
    quiet_reg <= RESET ? 4'hF : quiet_next;
  a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered next cycle");
  a_ack_needs_req: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  a_reset_pins_high: assert property ($past(RESET) |-> INT_PIN_FIRST_N && INT_PIN_SECOND_N && !WB_ACK_O)
    else $error("pins or ack active after reset");
  a_unmapped_reads_zero: assert property (WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O &&
    WB_ADR_I == 8'h30 |=> WB_DAT_O == 32'h0)
    else $error("unmapped read returned data");
  a_first_fall_cause: assert property ($fell(INT_PIN_FIRST_N) |-> quiet_reg <= 4'h6)
    else $error("first pin fell without event or write");
  a_second_fall_cause: assert property ($fell(INT_PIN_SECOND_N) |-> quiet_reg <= 4'h6)
    else $error("second pin fell without event or write");
  a_first_rise_cause: assert property ($rose(INT_PIN_FIRST_N) |-> $past(WB_CYC_I && WB_WE_I, 2) ||
    $past(WB_CYC_I && WB_WE_I, 3) || $past(WB_CYC_I && WB_WE_I, 4))
    else $error("first pin released without acknowledge");
  a_second_rise_cause: assert property ($rose(INT_PIN_SECOND_N) |-> quiet_reg <= 4'h4)
    else $error("second pin released without acknowledge");
endmodule : interrupt_event_pin_logic_monitor
bind interrupt_event_pin_logic interrupt_event_pin_logic_monitor mon (.CLK(CLK), .RESET(RESET),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .EVENT_FIRST(EVENT_FIRST), .EVENT_SECOND(EVENT_SECOND),
  .INT_PIN_FIRST_N(INT_PIN_FIRST_N), .INT_PIN_SECOND_N(INT_PIN_SECOND_N));

// ===== host_irq_watch.sv
// Host side model that counts request pin assertions
`timescale 1ns/1ps
module host_irq_watch (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       int_first_n,
  input  wire logic       int_second_n,
  output logic      [7:0] falls_first,
  output logic      [7:0] falls_second
);
  logic last_first, last_second;
  // Host takes each falling edge of an active low pin as one request
  always_ff @(posedge clk)
  begin
    last_first <= rst ? 1'b1 : int_first_n;
    last_second <= rst ? 1'b1 : int_second_n;
    falls_first <= rst ? 8'h00 : falls_first + {7'h00, last_first & ~int_first_n};
    falls_second <= rst ? 8'h00 : falls_second + {7'h00, last_second & ~int_second_n};
  end
endmodule : host_irq_watch

// ===== interrupt_event_pin_logic_tb_top.sv
// Self-checking bench of the interrupt and event block
`timescale 1ns/1ps
module interrupt_event_pin_logic_tb_top;
  logic        clk, rst, cyc, stb, we, ack, p4, rdy, n0, n1, sp;
  logic [7:0]  adr, falls0, falls1;
  logic [31:0] wd, rd, ev0, ev1, evl, rv;
  int          err_total, check_count;
  interrupt_event_pin_logic dut (.CLK(clk), .RESET(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .EVENT_FIRST(ev0),
    .EVENT_SECOND(ev1), .EVENT_LIVE(evl), .PER_PHASE_IDLE(32'h0000005A), .PER_PHASE_SIGN(32'h000000C3),
    .PULSE_OUT_FOUR(p4), .SAMPLE_READY_OUT(rdy), .INT_PIN_FIRST_N(n0), .INT_PIN_SECOND_N(n1), .SHARED_PIN(sp));
  host_irq_watch host (.clk(clk), .rst(rst), .int_first_n(n0), .int_second_n(n1),
    .falls_first(falls0), .falls_second(falls1));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One classic cycle; read data taken at the ack edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1);
    rv = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("ack_wait", n, 32'h2);
  endtask : bus
  // Hold event inputs two cycles, then wait past the four edge path
  task automatic pulse(input logic [31:0] f, input logic [31:0] s);
    ev0 <= f;
    ev1 <= s;
    repeat (2) @(posedge clk);
    ev0 <= 32'h0;
    ev1 <= 32'h0;
    repeat (6) @(posedge clk);
  endtask : pulse
  task automatic t_reset_and_detail;
    bus(1'b0, 8'h14, 32'h0);
    chk("ev_en", rv, 32'h0);
    bus(1'b0, 8'h08, 32'h0);
    chk("en_first", rv, 32'h0);
    bus(1'b0, 8'h30, 32'h0);
    chk("unmapped", rv, 32'h0);
    bus(1'b0, 8'h18, 32'h0);
    chk("idle_detail", rv, 32'h0000005A);
    bus(1'b0, 8'h1C, 32'h0);
    chk("sign_detail", rv, 32'h000000C3);
  endtask : t_reset_and_detail
  task automatic t_mask_and_clear;
    pulse(32'h4, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk("flag_masked", rv & 32'h4, 32'h4);
    chk("pin_masked", {31'h0, n0}, 32'h1);
    bus(1'b1, 8'h08, 32'h4);
    repeat (3) @(posedge clk);
    chk("pin_enabled", {31'h0, n0}, 32'h0);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk("flag_kept", rv & 32'h4, 32'h4);
    bus(1'b1, 8'h00, 32'h4);
    repeat (2) @(posedge clk);
    chk("pin_cleared", {31'h0, n0}, 32'h1);
    bus(1'b1, 8'h08, 32'h0);
  endtask : t_mask_and_clear
  task automatic t_nonmask;
    logic [7:0] f;
    f = falls0;
    pulse(32'h2, 32'h0);
    chk("nonmask_pin", {31'h0, n0}, 32'h0);
    chk("nonmask_falls", {24'h0, falls0}, {24'h0, f + 8'h01});
    chk("second_unmerged", {31'h0, n1}, 32'h1);
    bus(1'b1, 8'h00, 32'h2);
    repeat (2) @(posedge clk);
    chk("nonmask_clear", {31'h0, n0}, 32'h1);
  endtask : t_nonmask
  task automatic t_cross_and_merge;
    bus(1'b1, 8'h0C, 32'h1);
    pulse(32'h0, 32'h1);
    chk("cross_second", {31'h0, n1}, 32'h0);
    chk("cross_first", {31'h0, n0}, 32'h1);
    bus(1'b1, 8'h04, 32'h1);
    repeat (2) @(posedge clk);
    chk("cross_clear", {31'h0, n1}, 32'h1);
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h08, 32'h8);
    pulse(32'h8, 32'h0);
    chk("merge_first", {30'h0, n0, n1}, 32'h0);
    bus(1'b1, 8'h00, 32'h8);
    repeat (2) @(posedge clk);
    chk("merge_clear", {30'h0, n0, n1}, 32'h3);
    pulse(32'h0, 32'h1);
    chk("merge_own_first", {31'h0, n0}, 32'h1);
    chk("merge_own_second", {31'h0, n1}, 32'h0);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h10, 32'h0);
  endtask : t_cross_and_merge
  // Select 10 tracks enabled live sources; 11 and 00 carry the other functions
  task automatic t_event_out;
    bus(1'b1, 8'h10, 32'h4);
    bus(1'b1, 8'h14, 32'h20);
    evl <= 32'h40;
    repeat (5) @(posedge clk);
    chk("ev_disabled", {31'h0, sp}, 32'h1);
    evl <= 32'h60;
    repeat (5) @(posedge clk);
    chk("ev_active", {31'h0, sp}, 32'h0);
    evl <= 32'h40;
    repeat (5) @(posedge clk);
    chk("ev_follow", {31'h0, sp}, 32'h1);
    evl <= 32'h60;
    rdy <= 1'b1;
    bus(1'b1, 8'h10, 32'h6);
    repeat (4) @(posedge clk);
    chk("sel_ready", {31'h0, sp}, 32'h1);
    bus(1'b0, 8'h20, 32'h0);
    chk("live_read", rv, 32'h00000060);
    bus(1'b1, 8'h10, 32'h0);
    repeat (4) @(posedge clk);
    chk("sel_pulse", {31'h0, sp}, 32'h0);
    // Select 01 must also give the pulse function, not the event level
    p4 <= 1'b1;
    bus(1'b1, 8'h10, 32'h2);
    repeat (4) @(posedge clk);
    chk("sel_pulse_alt", {31'h0, sp}, 32'h1);
  endtask : t_event_out
  // Reset in mid-run drops pending flags and disables the event sources again
  task automatic t_mid_reset;
    pulse(32'h1, 32'h0);
    chk("rst_flag_pin", {31'h0, n0}, 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk("rst_pin_high", {31'h0, n0}, 32'h1);
    bus(1'b0, 8'h00, 32'h0);
    chk("rst_flags", rv, 32'h0);
    bus(1'b0, 8'h14, 32'h0);
    chk("rst_ev_en", rv, 32'h0);
  endtask : t_mid_reset
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial
  begin
    {rst, cyc, stb, we, p4, rdy} = 6'h20;
    {adr, wd, ev0, ev1, evl} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset_and_detail();
    t_mask_and_clear();
    t_nonmask();
    t_cross_and_merge();
    t_event_out();
    t_mid_reset();
    report_and_stop();
  end
endmodule : interrupt_event_pin_logic_tb_top
